// ---- hdl/sadma_params.svh ----
// Constants for the short-address DMA channel: register offsets, field positions,
// reset values. Assumes byte addresses on an 8-bit APB address bus.
`ifndef SADMA_PARAMS_SVH
`define SADMA_PARAMS_SVH

// ************************************************
// Register offsets
// ************************************************
`define SADMA_OFF_MEM_ADDR 8'h00
`define SADMA_OFF_FIX_ADDR 8'h04
`define SADMA_OFF_COUNT 8'h08
`define SADMA_OFF_CTRL 8'h0c
`define SADMA_OFF_STATUS 8'h10
`define SADMA_OFF_MASK 8'h14

// ************************************************
// Control and status fields
// ************************************************
`define SADMA_CTL_TE 0
`define SADMA_CTL_EIE 1
`define SADMA_CTL_RPT 2
`define SADMA_CTL_DIR 3
`define SADMA_CTL_WORD 4
`define SADMA_CTL_DEC 5
`define SADMA_CTL_SEL_LO 8
`define SADMA_STS_END 0
`define SADMA_STS_XFER 1

// ************************************************
// Fixed values and reset values
// ************************************************
`define SADMA_FIXED_HIGH 8'hff
`define SADMA_NUM_SRC 6
`define SADMA_RST_ADDR 24'h000000
`define SADMA_RST_FIX 16'h0000
`define SADMA_RST_CNT 16'h0000
`define SADMA_RST_CTL 6'h00
`define SADMA_RST_STS 2'h0

`endif

// ---- hdl/sadma_pkg.sv ----
// Types shared by the short-address DMA channel modules.
// Assumes nothing of its surroundings.
package sadma_pkg;

	// Transfer engine phases
	typedef enum logic [1:0] {
		SADMA_ENG_IDLE = 2'b00,
		SADMA_ENG_READ = 2'b01,
		SADMA_ENG_WRITE = 2'b10
	} sadma_eng_state_t;

	// Activation source codes; 6 and 7 select nothing
	typedef enum logic [2:0] {
		SADMA_SRC_ADC_END = 3'b000,
		SADMA_SRC_SER_TX = 3'b001,
		SADMA_SRC_SER_RX = 3'b010,
		SADMA_SRC_TMR0_A = 3'b011,
		SADMA_SRC_TMR1_A = 3'b100,
		SADMA_SRC_TMR2_A = 3'b101,
		SADMA_SRC_NONE6 = 3'b110,
		SADMA_SRC_NONE7 = 3'b111
	} sadma_src_t;

endpackage : sadma_pkg

// ---- hdl/sadma_req_sel.sv ----
// Activation request selector: picks one peripheral interrupt line and holds it pending.
// Assumes request lines are synchronous one-cycle or level strobes from on-chip peripherals.
`timescale 1ns/1ps
`include "sadma_params.svh"

module sadma_req_sel
(
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic [`SADMA_NUM_SRC-1:0] i_req,
	input wire sadma_pkg::sadma_src_t i_sel,
	input wire logic i_enable,
	input wire logic i_take,
	output logic o_pending
);
	import sadma_pkg::*;

	// ************************************************
	// Source decode
	// ************************************************
	// Only the six peripheral lines can activate the channel
	wire [2:0] sel_idx = i_sel;
	wire sel_valid = (sel_idx < 3'd6);
	wire sel_hit = sel_valid & i_req[sel_idx];
	// New request wins over a take in the same cycle, so none is lost
	wire pending_next = i_enable & (sel_hit | (o_pending & ~i_take));

	// Pending flag
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			o_pending <= 1'b0;
		else
			o_pending <= pending_next;
	end

	property p_src_only;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		$rose(o_pending) |-> $past(sel_hit) && $past(i_enable);
	endproperty
	a_src_only: assert property (p_src_only) else $error("pending rose without selected source");

endmodule : sadma_req_sel

// ---- hdl/sadma_xfer_eng.sv ----
// Dual-address transfer engine: one read from the source, one write to the destination.
// Assumes an internal bus slave that acknowledges each held request with i_bus_ack.
`timescale 1ns/1ps

module sadma_xfer_eng
(
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic i_start,
	input wire logic [23:0] i_src_addr,
	input wire logic [23:0] i_dst_addr,
	input wire logic i_word,
	output logic o_busy,
	output logic o_done,
	output logic o_bus_req,
	output logic o_bus_wr,
	output logic o_bus_word,
	output logic [23:0] o_bus_addr,
	output logic [15:0] o_bus_wdata,
	input wire logic i_bus_ack,
	input wire logic [15:0] i_bus_rdata
);
	import sadma_pkg::*;

	sadma_eng_state_t state_reg;
	logic [23:0] dst_reg;

	// Byte transfers carry the low lane only
	wire [15:0] rd_data = o_bus_word ? i_bus_rdata : {8'h00, i_bus_rdata[7:0]};

	// ************************************************
	// Read then write sequence
	// ************************************************
	// Request and address are held until the bus acknowledges
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			state_reg <= SADMA_ENG_IDLE;
			dst_reg <= 24'h000000;
			o_busy <= 1'b0;
			o_done <= 1'b0;
			o_bus_req <= 1'b0;
			o_bus_wr <= 1'b0;
			o_bus_word <= 1'b0;
			o_bus_addr <= 24'h000000;
			o_bus_wdata <= 16'h0000;
		end
		else
		begin
			o_done <= 1'b0;
			unique case (state_reg)
				SADMA_ENG_IDLE:
					if (i_start)
					begin
						state_reg <= SADMA_ENG_READ;
						o_busy <= 1'b1;
						o_bus_req <= 1'b1;
						o_bus_wr <= 1'b0;
						o_bus_word <= i_word;
						o_bus_addr <= i_src_addr;
						dst_reg <= i_dst_addr;
					end
				SADMA_ENG_READ:
					if (i_bus_ack)
					begin
						state_reg <= SADMA_ENG_WRITE;
						o_bus_wr <= 1'b1;
						o_bus_addr <= dst_reg;
						o_bus_wdata <= rd_data;
					end
				SADMA_ENG_WRITE:
					if (i_bus_ack)
					begin
						state_reg <= SADMA_ENG_IDLE;
						o_bus_req <= 1'b0;
						o_bus_wr <= 1'b0;
						o_busy <= 1'b0;
						o_done <= 1'b1;
					end
				default:
					state_reg <= SADMA_ENG_IDLE;
			endcase
		end
	end

	sequence s_launch;
		i_start && !o_busy;
	endsequence

	property p_read_first;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		s_launch |=> o_bus_req && !o_bus_wr && o_bus_addr == $past(i_src_addr);
	endproperty
	a_read_first: assert property (p_read_first) else $error("transfer did not start with source read");

endmodule : sadma_xfer_eng

// ---- hdl/sadma_top.sv ----
// Short-address DMA channel: APB register file, sequencing and interrupts.
// Assumes APB master on i_ref_clk and an internal bus slave that acknowledges each access.
//
// How it works
// - With repeat_select at 0 the channel runs in sequential mode.
// - In sequential mode each request moves one unit and then steps the memory address, for the programmed count.
// - The memory address is 24 bits and steps up or down by 1 for bytes and by 2 for words.
// - The fixed-side address is the 16-bit register with the upper 8 bits forced to ones and never changes.
// - direction_select 0 reads memory and writes the fixed side; 1 swaps them.
// - The 16-bit count drops by one per transfer and at zero clears transfer_enable and stops.
// - At the end of a run with end_interrupt_enable set, an interrupt request is raised.
// - A count loaded with zero gives 65,536 transfers.
// - Only A/D end, serial transmit, serial receive and timer 0 to 2 channel A events activate transfers.
// - With repeat_select and end_interrupt_enable both 1 the channel runs in idle mode.
// - In idle mode each request moves exactly one unit, for the programmed count.
// - In idle mode the memory address stays unchanged after every transfer.
// - While end_interrupt_enable is 1 and transfer_enable 0 the end interrupt stays pending until either changes.
//
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "sadma_params.svh"

module sadma_top
(
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire logic [`SADMA_NUM_SRC-1:0] i_xfer_req,
	output logic o_bus_req,
	output logic o_bus_wr,
	output logic o_bus_word,
	output logic [23:0] o_bus_addr,
	output logic [15:0] o_bus_wdata,
	input wire logic i_bus_ack,
	input wire logic [15:0] i_bus_rdata,
	output logic o_end_irq,
	output logic o_irq
);
	import sadma_pkg::*;

	// ************************************************
	// Helpers
	// ************************************************
	// Address step shared by the update path and its check
	function automatic logic [23:0] step_addr(input logic [23:0] addr, input logic word, input logic dec);
		logic [23:0] delta;
		delta = word ? 24'h000002 : 24'h000001;
		step_addr = dec ? addr - delta : addr + delta;
	endfunction : step_addr

	// ************************************************
	// Registers
	// ************************************************
	logic [23:0] mar_reg;
	logic [15:0] fixed_side_address_reg;
	logic [15:0] cnt_reg;
	logic [5:0] ctl_reg;
	sadma_src_t sel_reg;
	logic [1:0] sts_reg;
	logic [1:0] mask_reg;
	logic start_reg;
	logic pending;
	logic eng_busy;
	logic eng_done;

	// ************************************************
	// APB decode
	// ************************************************
	// One wait state so read data can come from a flip-flop
	wire acc = i_psel & i_penable;
	wire wr_fire = acc & o_pready & i_pwrite;
	wire hit_mar = (i_paddr == `SADMA_OFF_MEM_ADDR);
	wire hit_fixed_side_address = (i_paddr == `SADMA_OFF_FIX_ADDR);
	wire hit_cnt = (i_paddr == `SADMA_OFF_COUNT);
	wire hit_ctl = (i_paddr == `SADMA_OFF_CTRL);
	wire hit_sts = (i_paddr == `SADMA_OFF_STATUS);
	wire hit_mask = (i_paddr == `SADMA_OFF_MASK);
	wire hit_any = hit_mar | hit_fixed_side_address | hit_cnt | hit_ctl | hit_sts | hit_mask;
	wire [31:0] rd_mux = hit_mar ? {8'h00, mar_reg} :
		hit_fixed_side_address ? {16'h0000, fixed_side_address_reg} :
		hit_cnt ? {16'h0000, cnt_reg} :
		hit_ctl ? {21'h000000, sel_reg, 2'h0, ctl_reg} :
		hit_sts ? {30'h00000000, sts_reg} :
		hit_mask ? {30'h00000000, mask_reg} : 32'h00000000;

	// ************************************************
	// Mode and address selection
	// ************************************************
	wire te = ctl_reg[`SADMA_CTL_TE];
	wire eie = ctl_reg[`SADMA_CTL_EIE];
	wire rpt = ctl_reg[`SADMA_CTL_RPT];
	wire dir = ctl_reg[`SADMA_CTL_DIR];
	wire word = ctl_reg[`SADMA_CTL_WORD];
	wire dec = ctl_reg[`SADMA_CTL_DEC];
	wire mode_seq = ~rpt;
	wire mode_idle = rpt & eie;
	// Repeat mode proper is not built here, so that combination never starts
	wire mode_ok = mode_seq | mode_idle;
	wire [23:0] fix_addr = {`SADMA_FIXED_HIGH, fixed_side_address_reg};
	wire [23:0] src_addr = dir ? fix_addr : mar_reg;
	wire [23:0] dst_addr = dir ? mar_reg : fix_addr;
	// No start in the cycle a transfer retires, since the count may end the run then
	wire go = pending & te & mode_ok & ~eng_busy & ~start_reg & ~eng_done;
	wire [15:0] cnt_dec = cnt_reg - 16'h0001;
	wire end_of_run = eng_done & (cnt_dec == 16'h0000);
	wire end_pend = eie & ~te;
	wire [1:0] sts_set = {eng_done, end_of_run};
	wire [1:0] sts_clr = (wr_fire & hit_sts) ? i_pwdata[1:0] : 2'h0;
	wire [1:0] sts_next = (sts_reg & ~sts_clr) | sts_set;

	// ************************************************
	// APB response
	// ************************************************
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_pready <= 1'b0;
			o_prdata <= 32'h00000000;
			o_pslverr <= 1'b0;
		end
		else
		begin
			o_pready <= acc & ~o_pready;
			o_prdata <= (acc & ~o_pready & ~i_pwrite) ? rd_mux : 32'h00000000;
			o_pslverr <= acc & ~o_pready & ~hit_any;
		end
	end

	// ************************************************
	// Address and count registers
	// ************************************************
	// Software write wins over the hardware update in the same cycle
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			mar_reg <= `SADMA_RST_ADDR;
			fixed_side_address_reg <= `SADMA_RST_FIX;
			cnt_reg <= `SADMA_RST_CNT;
		end
		else
		begin
			if (wr_fire & hit_mar)
				mar_reg <= i_pwdata[23:0];
			else if (eng_done & mode_seq)
				mar_reg <= step_addr(mar_reg, word, dec);
			if (wr_fire & hit_fixed_side_address)
				fixed_side_address_reg <= i_pwdata[15:0];
			if (wr_fire & hit_cnt)
				cnt_reg <= i_pwdata[15:0];
			else if (eng_done)
				cnt_reg <= cnt_dec;
		end
	end

	// ************************************************
	// Control, status and mask
	// ************************************************
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			ctl_reg <= `SADMA_RST_CTL;
			sel_reg <= SADMA_SRC_ADC_END;
			sts_reg <= `SADMA_RST_STS;
			mask_reg <= `SADMA_RST_STS;
		end
		else
		begin
			if (wr_fire & hit_ctl)
			begin
				ctl_reg <= i_pwdata[5:0];
				sel_reg <= sadma_src_t'(i_pwdata[`SADMA_CTL_SEL_LO+2:`SADMA_CTL_SEL_LO]);
			end
			else if (end_of_run)
				ctl_reg[`SADMA_CTL_TE] <= 1'b0;
			sts_reg <= sts_next;
			if (wr_fire & hit_mask)
				mask_reg <= i_pwdata[1:0];
		end
	end

	// ************************************************
	// Start strobe and interrupt outputs
	// ************************************************
	// Outputs lag their cause by one cycle so they come from flip-flops
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			start_reg <= 1'b0;
			o_end_irq <= 1'b0;
			o_irq <= 1'b0;
		end
		else
		begin
			start_reg <= go;
			o_end_irq <= end_pend;
			o_irq <= |(sts_reg & mask_reg);
		end
	end

	// ************************************************
	// Submodules
	// ************************************************
	sadma_req_sel u_req_sel
	(
		.i_ref_clk(i_ref_clk),
		.i_rst_n(i_rst_n),
		.i_req(i_xfer_req),
		.i_sel(sel_reg),
		.i_enable(te),
		.i_take(go),
		.o_pending(pending)
	);

	sadma_xfer_eng u_xfer_eng
	(
		.i_ref_clk(i_ref_clk),
		.i_rst_n(i_rst_n),
		.i_start(start_reg),
		.i_src_addr(src_addr),
		.i_dst_addr(dst_addr),
		.i_word(word),
		.o_busy(eng_busy),
		.o_done(eng_done),
		.o_bus_req(o_bus_req),
		.o_bus_wr(o_bus_wr),
		.o_bus_word(o_bus_word),
		.o_bus_addr(o_bus_addr),
		.o_bus_wdata(o_bus_wdata),
		.i_bus_ack(i_bus_ack),
		.i_bus_rdata(i_bus_rdata)
	);

	// ************************************************
	// Checks
	// ************************************************
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_rst_n);

	sequence s_hw_step;
		eng_done && !wr_fire;
	endsequence

	property p_cnt_dec;
		s_hw_step ##0 !hit_cnt |=> cnt_reg == $past(cnt_reg) - 16'h0001;
	endproperty
	a_cnt_dec: assert property (p_cnt_dec) else $error("count did not drop after transfer");

	property p_run_end;
		s_hw_step ##0 cnt_reg == 16'h0001 |=> !ctl_reg[`SADMA_CTL_TE] && sts_reg[`SADMA_STS_END];
	endproperty
	a_run_end: assert property (p_run_end) else $error("run end did not clear enable");

	property p_max_run;
		s_hw_step ##0 cnt_reg == 16'h0000 && te |=> cnt_reg == 16'hffff && ctl_reg[`SADMA_CTL_TE];
	endproperty
	a_max_run: assert property (p_max_run) else $error("zero count ended the run early");

	property p_mar_seq;
		s_hw_step ##0 mode_seq |=> mar_reg == step_addr($past(mar_reg), $past(word), $past(dec));
	endproperty
	a_mar_seq: assert property (p_mar_seq) else $error("memory address step wrong");

	property p_mar_idle;
		s_hw_step ##0 mode_idle |=> $stable(mar_reg);
	endproperty
	a_mar_idle: assert property (p_mar_idle) else $error("memory address moved in idle mode");

	property p_end_irq;
		end_pend |=> o_end_irq;
	endproperty
	a_end_irq: assert property (p_end_irq) else $error("end interrupt not held");

	property p_end_cancel;
		!end_pend |=> !o_end_irq;
	endproperty
	a_end_cancel: assert property (p_end_cancel) else $error("end interrupt not cancelled");

	property p_irq_after_end;
		end_of_run && mask_reg[`SADMA_STS_END] && !wr_fire |=> ##1 o_irq;
	endproperty
	a_irq_after_end: assert property (p_irq_after_end) else $error("run end raised no interrupt");

	property p_no_start_off;
		!te |=> !start_reg;
	endproperty
	a_no_start_off: assert property (p_no_start_off) else $error("transfer started while disabled");

	property p_repeat_halt;
		rpt && !eie |=> !start_reg;
	endproperty
	a_repeat_halt: assert property (p_repeat_halt) else $error("transfer started in unsupported mode");

	property p_fixed_dst;
		o_bus_req && o_bus_wr && !dir && !wr_fire |-> o_bus_addr[23:16] == `SADMA_FIXED_HIGH;
	endproperty
	a_fixed_dst: assert property (p_fixed_dst) else $error("fixed side address upper byte wrong");

endmodule : sadma_top

// ---- dv/sadma_bus_model.sv ----
// Behavioural internal bus slave facing the DMA channel.
// Assumes one held request at a time, accepted by a one-cycle o_ack.
`timescale 1ns/1ps

module sadma_bus_model
(
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic i_req,
	input wire logic i_wr,
	input wire logic i_word,
	input wire logic [23:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic [3:0] i_wait,
	output logic o_ack,
	output logic [15:0] o_rdata
);
	logic [3:0] wait_reg;
	int wr_count;
	logic [23:0] last_wr_addr;
	logic [23:0] last_rd_addr;
	logic [15:0] last_wr_data;
	logic last_word;

	// Ack after i_wait stall cycles; read data is a pattern of the address
	// Data lines toggle between answers, so stale data never looks fresh
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			wait_reg <= 4'h0;
			wr_count <= 0;
			last_wr_addr <= 24'h000000;
			last_rd_addr <= 24'h000000;
			last_wr_data <= 16'h0000;
			last_word <= 1'b0;
			o_ack <= 1'b0;
			o_rdata <= 16'h0000;
		end
		else
		begin
			o_ack <= 1'b0;
			o_rdata <= ~o_rdata;
			if (i_req && !o_ack && wait_reg >= i_wait)
			begin
				wait_reg <= 4'h0;
				o_ack <= 1'b1;
				if (i_wr)
				begin
					wr_count <= wr_count + 1;
					last_wr_addr <= i_addr;
					last_wr_data <= i_wdata;
					last_word <= i_word;
				end
				else
				begin
					last_rd_addr <= i_addr;
					o_rdata <= {8'h5a ^ i_addr[7:0], i_addr[7:0]};
				end
			end
			else if (i_req && !o_ack)
				wait_reg <= wait_reg + 4'h1;
		end
	end
endmodule : sadma_bus_model

// ---- dv/tb_short_address_dma_channel.sv ----
// Self-checking bench for the short-address DMA channel over APB.
// Assumes the bus model beside it and the register map of the params header.
`timescale 1ns/1ps
`include "sadma_params.svh"

module tb_short_address_dma_channel;
	import sadma_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [5:0] xreq = 6'h00;
	logic [3:0] wait_n = 4'h0;
	logic [31:0] prdata;
	logic pready, pslverr, breq, bwr, bword, back, end_irq, irq;
	logic [23:0] baddr;
	logic [15:0] bwdata, brdata;
	int fail_count = 0;
	int samples_checked = 0;

	// ************************************************
	// Design and far side
	// ************************************************
	sadma_top uut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
		.i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
		.i_xfer_req(xreq), .o_bus_req(breq), .o_bus_wr(bwr), .o_bus_word(bword), .o_bus_addr(baddr),
		.o_bus_wdata(bwdata), .i_bus_ack(back), .i_bus_rdata(brdata), .o_end_irq(end_irq), .o_irq(irq));
	sadma_bus_model mdl (.i_ref_clk(clk), .i_rst_n(rst_n), .i_req(breq), .i_wr(bwr), .i_word(bword), .i_addr(baddr),
		.i_wdata(bwdata), .i_wait(wait_n), .o_ack(back), .o_rdata(brdata));

	// 100 MHz clock
	initial
	begin
		forever #5 clk = ~clk;
	end

	// ************************************************
	// Tasks
	// ************************************************
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : summarize

	task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e)
		begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask : check

	// One APB transfer; the reply is taken at the edge where pready is sampled high, before the design updates
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
		output logic err);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		q = prdata;
		err = pslverr;
		if (pready !== 1'b1)
			check("pready", 0, 1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
		logic [31:0] q;
		logic e;
		apb(1'b0, a, 32'h0, q, e);
		check($sformatf("reg %h", a), q, x);
		check("pslverr", {31'h0, e}, {31'h0, xe});
	endtask : rd

	// Strobe request lines, then see whether exactly go transfers followed
	task automatic fire(input logic [5:0] m, input int go);
		int n;
		int c0;
		c0 = mdl.wr_count;
		@(posedge clk);
		xreq <= m;
		@(posedge clk);
		xreq <= 6'h00;
		n = 0;
		while (mdl.wr_count == c0 && n < 40)
		begin
			@(posedge clk);
			n++;
		end
		repeat (6) @(posedge clk);
		@(negedge clk);
		check("transfers", mdl.wr_count - c0, go);
	endtask : fire

	task automatic xfer_chk(input logic [23:0] ra, input logic [23:0] wa, input logic [15:0] wd, input logic xw);
		check("word size", mdl.last_word, xw);
		check("read addr", mdl.last_rd_addr, ra);
		check("write addr", mdl.last_wr_addr, wa);
		check("write data", mdl.last_wr_data, wd);
	endtask : xfer_chk

	// Hang guard
	initial
	begin
		repeat (30000) @(posedge clk);
		fail_count++;
		summarize();
	end

	// ************************************************
	// Scenarios
	// ************************************************
	initial
	begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 6; i++)
			rd(8'(i * 4), 32'h0, 1'b0);
		rd(8'h18, 32'h0, 1'b1);
		// Sequential, byte, increment, memory to fixed side, A/D end source
		wr(`SADMA_OFF_MEM_ADDR, 32'h10);
		wr(`SADMA_OFF_FIX_ADDR, 32'h1234);
		wr(`SADMA_OFF_COUNT, 32'h3);
		wr(`SADMA_OFF_MASK, 32'h1);
		wr(`SADMA_OFF_CTRL, 32'h3);
		fire(6'h02, 0);
		for (int i = 0; i < 3; i++)
		begin
			fire(6'h01, 1);
			xfer_chk(24'(24'h10 + i), 24'hff1234, 16'(8'h10 + i), 1'b0);
		end
		rd(`SADMA_OFF_COUNT, 32'h0, 1'b0);
		rd(`SADMA_OFF_CTRL, 32'h2, 1'b0);
		rd(`SADMA_OFF_MEM_ADDR, 32'h13, 1'b0);
		rd(`SADMA_OFF_STATUS, 32'h3, 1'b0);
		check("end irq", end_irq, 1'b1);
		check("irq", irq, 1'b1);
		fire(6'h01, 0);
		wr(`SADMA_OFF_STATUS, 32'h1);
		rd(`SADMA_OFF_STATUS, 32'h2, 1'b0);
		check("irq", irq, 1'b0);
		wr(`SADMA_OFF_CTRL, 32'h0);
		repeat (2) @(posedge clk);
		@(negedge clk);
		check("end irq", end_irq, 1'b0);
		// Sequential, word, decrement, fixed side to memory, slow far side
		wait_n <= 4'h3;
		wr(`SADMA_OFF_MEM_ADDR, 32'h100);
		wr(`SADMA_OFF_FIX_ADDR, 32'h40);
		wr(`SADMA_OFF_COUNT, 32'h2);
		wr(`SADMA_OFF_CTRL, 32'h339);
		for (int i = 0; i < 2; i++)
		begin
			fire(6'h08, 1);
			xfer_chk(24'hff0040, 24'(24'h100 - 2 * i), 16'h1a40, 1'b1);
		end
		rd(`SADMA_OFF_MEM_ADDR, 32'hfc, 1'b0);
		// Idle mode: address fixed, end interrupt held then cancelled by restart
		wait_n <= 4'h0;
		wr(`SADMA_OFF_MEM_ADDR, 32'h20);
		wr(`SADMA_OFF_COUNT, 32'h2);
		wr(`SADMA_OFF_CTRL, 32'h207);
		for (int i = 0; i < 2; i++)
		begin
			fire(6'h04, 1);
			xfer_chk(24'h20, 24'hff0040, 16'h0020, 1'b0);
		end
		rd(`SADMA_OFF_MEM_ADDR, 32'h20, 1'b0);
		rd(`SADMA_OFF_CTRL, 32'h206, 1'b0);
		check("end irq", end_irq, 1'b1);
		wr(`SADMA_OFF_CTRL, 32'h207);
		repeat (2) @(posedge clk);
		@(negedge clk);
		check("end irq", end_irq, 1'b0);
		fire(6'h04, 1);
		fire(6'h04, 1);
		rd(`SADMA_OFF_COUNT, 32'hfffe, 1'b0);
		rd(`SADMA_OFF_CTRL, 32'h207, 1'b0);
		// Repeat-only setting never starts
		wr(`SADMA_OFF_COUNT, 32'h1);
		wr(`SADMA_OFF_CTRL, 32'h5);
		fire(6'h01, 0);
		// Drop the request left pending by the refused mode before the next setting
		wr(`SADMA_OFF_CTRL, 32'h0);
		// Every source code: the six valid ones with a wrong line strobed first, 6 and 7 with all lines strobed
		for (int s = 0; s < 6; s++)
		begin
			wr(`SADMA_OFF_COUNT, 32'h1);
			wr(`SADMA_OFF_CTRL, 32'(s * 256 + 1));
			fire(6'(1 << ((s + 1) % 6)), 0);
			fire(6'(1 << s), 1);
		end
		wr(`SADMA_OFF_COUNT, 32'h1);
		for (int s = 6; s < 8; s++)
		begin
			wr(`SADMA_OFF_CTRL, 32'(s * 256 + 1));
			fire(6'h3f, 0);
		end
		// Reset in mid-transfer: bus released, registers back to zero
		wait_n <= 4'hf;
		wr(`SADMA_OFF_COUNT, 32'h2);
		wr(`SADMA_OFF_CTRL, 32'h1);
		@(posedge clk);
		xreq <= 6'h01;
		repeat (6) @(posedge clk);
		check("bus req", breq, 1'b1);
		rst_n <= 1'b0;
		xreq <= 6'h00;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		check("bus req", breq, 1'b0);
		check("end irq", end_irq, 1'b0);
		rd(`SADMA_OFF_COUNT, 32'h0, 1'b0);
		rd(`SADMA_OFF_CTRL, 32'h0, 1'b0);
		wait_n <= 4'h0;
		summarize();
	end
endmodule : tb_short_address_dma_channel
